// ==== shared/dma_defines.vh ====
/*
 * Constants of the two-channel transfer controller: register map, control
 * field positions, reset values, request-source codes and timing counts.
 * Assumes it is included by bare name from the design files.
 */
`ifndef DMA_DEFINES_VH
`define DMA_DEFINES_VH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define PTR_W 20
`define CNT_W 16
`define NUM_CH 2

// ----------------------------------------------------------------------
// register map: haddr[6] picks the global block, haddr[5] the channel,
// haddr[4:2] the word inside the block
// ----------------------------------------------------------------------
`define ADR_GLOBAL_BIT 6
`define ADR_CHAN_BIT 5
`define ADR_WORD_HI 4
`define ADR_WORD_LO 2
`define REG_CTRL 3'h0
`define REG_SRC 3'h1
`define REG_DST 3'h2
`define REG_RELOAD 3'h3
`define REG_FWD 3'h4
`define REG_COUNT 3'h5
`define REG_STATUS 3'h0
`define REG_MASK 3'h1

// ----------------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------------
`define CTL_EN 0
`define CTL_DIR 1
`define CTL_EDGE 2
`define CTL_REQ 3
`define CTL_SWREQ 4
`define CTL_SEL_LO 5
`define CTL_SEL_HI 6

// request source codes
`define SRC_PERIPH 2'h0
`define SRC_SOFT 2'h1
`define SRC_PIN 2'h2

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define RST_PTR 20'h00000
`define RST_CNT 16'h0000
`define RST_SEL 2'h0
`define RST_WORD 32'h00000000
`define XFER_LEN 2'h2
`define ONE_CNT 16'h0001
`define ONE_PTR 20'h00001

`endif

// ==== hw/pin_sync.v ====
/*
 * Two-flop synchroniser for a group of asynchronous pins.
 * Assumes the pins may change at any time relative to ref_clk.
 */
`timescale 1ns/100ps
`include "dma_defines.vh"

module pin_sync #(
  parameter WIDTH = 2
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // pins and synchronised levels
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] pinSync
);

  reg [WIDTH-1:0] pinMeta;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // reset to the idle-high level so no false edge follows reset
      pinMeta <= {WIDTH{1'b1}};
      pinSync <= {WIDTH{1'b1}};
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

endmodule // pin_sync

// ==== hw/dma_request_enable_logic.v ====
/*
 * Two-channel transfer controller: enable and reload, request latching
 * from peripheral, software and pin sources, fixed channel priority and
 * bus hand-back to the CPU, with an AHB-Lite register slave.
 * Assumes one 10 MHz clock, a CPU that reports its pending bus access on
 * the same clock, and pins that are asynchronous.
 */
// Local design decisions: the placing of the registers and register access over AHB-Lite.
// How it works
// - enable write activates; first transfer loads forward pointer
// - first transfer loads counter from reload register
// - enable rewrite while active restarts both reloads
// - request bit sets regardless of enable state
// - request bit clears on the same edge that the transfer begins
// - software writes 0 clear request; 1 ignored
// - active channel with request starts transfer at once
// - enable bit reads back channel activity
// - peripheral source sets request with its interrupt flag
// - selected pin input becomes the transfer request
// - pin request follows the selected pin edge
// - simultaneous requests set all request bits together
// - channel zero first, CPU access, then channel one
// - software request bit triggers transfer, reads zero
`timescale 1ns/100ps
`include "dma_defines.vh"

module dma_request_enable_logic (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // request sources
  input wire [1:0] periphIrq,
  input wire [1:0] external_irq_pin,
  // bus sharing with the CPU
  input wire cpuBusReq,
  input wire cpuAccessDone,
  output reg dmaOwnsBus,
  output reg dmaChan,
  output reg [`PTR_W-1:0] dmaAddr,
  // interrupt
  output reg irq
);

  localparam ST_IDLE = 2'b00;
  localparam ST_XFER = 2'b01;
  localparam ST_CPU = 2'b10;

  // ----------------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------------
  function isChanWord;
    input [31:0] adr;
    input chan;
    input [2:0] word;
    begin
      isChanWord = !adr[`ADR_GLOBAL_BIT] && (adr[`ADR_CHAN_BIT] == chan) &&
        (adr[`ADR_WORD_HI:`ADR_WORD_LO] == word);
    end
  endfunction

  function isGlobalWord;
    input [31:0] adr;
    input [2:0] word;
    begin
      isGlobalWord = adr[`ADR_GLOBAL_BIT] && !adr[`ADR_CHAN_BIT] &&
        (adr[`ADR_WORD_HI:`ADR_WORD_LO] == word);
    end
  endfunction

  // ----------------------------------------------------------------------
  // AHB-Lite slave: one wait state on every transfer
  // ----------------------------------------------------------------------
  reg dataPhase;
  reg phaseWrite;
  reg [31:0] phaseAddr;
  wire takeReq = hsel && htrans[1] && hready;
  wire wrStrobe = dataPhase && phaseWrite;
  wire rdStrobe = dataPhase && !phaseWrite;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataPhase <= 1'b0;
      phaseWrite <= 1'b0;
      phaseAddr <= `RST_WORD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (takeReq && !dataPhase) begin
        dataPhase <= 1'b1;
        phaseWrite <= hwrite;
        phaseAddr <= haddr;
        hreadyout <= 1'b0;
      end else begin
        dataPhase <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  wire [1:0] pinLevel;

  pin_sync #(
    .WIDTH(`NUM_CH)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(external_irq_pin),
    .pinSync(pinLevel)
  );

  // ----------------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------------
  reg [1:0] state;
  reg [1:0] xferCnt;
  wire [1:0] chEnable;
  wire [1:0] chReq;
  wire [`PTR_W-1:0] chStartAddr [0:1];
  wire [`PTR_W-1:0] chNextAddr [0:1];
  wire [1:0] chReady = chEnable & chReq;
  wire startFire = (state == ST_IDLE) && (|chReady);
  wire startSel = !chReady[0];
  wire xferEnd = (state == ST_XFER) && (xferCnt == `XFER_LEN);
  wire [1:0] doneEvt;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      xferCnt <= 2'h0;
      dmaOwnsBus <= 1'b0;
      dmaChan <= 1'b0;
      dmaAddr <= `RST_PTR;
    end else begin
      case (state)
        ST_IDLE: begin
          if (startFire) begin
            state <= ST_XFER;
            xferCnt <= 2'h1;
            dmaOwnsBus <= 1'b1;
            dmaChan <= startSel;
            dmaAddr <= chStartAddr[startSel];
          end
        end
        ST_XFER: begin
          if (xferEnd) begin
            state <= ST_CPU;
            dmaOwnsBus <= 1'b0;
          end else begin
            xferCnt <= xferCnt + 2'h1;
            dmaAddr <= chNextAddr[dmaChan];
          end
        end
        ST_CPU: begin
          if (cpuAccessDone || !cpuBusReq) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // per-channel enable, request, pointers and counter
  // ----------------------------------------------------------------------
  wire [31:0] chRead [0:1];

  genvar i;
  generate
    for (i = 0; i < `NUM_CH; i = i + 1) begin : g_ch
      localparam [0:0] CH_ID = (i != 0);
      reg enable;
      reg dir;
      reg edgeRise;
      reg req;
      reg firstPending;
      reg [1:0] sel;
      reg [`PTR_W-1:0] srcPtr;
      reg [`PTR_W-1:0] dstPtr;
      reg [`PTR_W-1:0] fwdPtr;
      reg [`CNT_W-1:0] reload;
      reg [`CNT_W-1:0] count;
      reg pinLast;
      wire ctlWr = wrStrobe && isChanWord(phaseAddr, CH_ID, `REG_CTRL);
      wire myStart = startFire && (startSel == CH_ID);
      wire myEnd = xferEnd && (dmaChan == CH_ID);
      wire pinEdge = edgeRise ? (pinLevel[i] && !pinLast)
                              : (!pinLevel[i] && pinLast);
      wire softHit = ctlWr && hwdata[`CTL_SWREQ] &&
        (hwdata[`CTL_SEL_HI:`CTL_SEL_LO] == `SRC_SOFT);
      wire reqEvt = ((sel == `SRC_PERIPH) && periphIrq[i]) ||
        ((sel == `SRC_PIN) && pinEdge) || softHit;
      wire reqClr = myStart || (ctlWr && !hwdata[`CTL_REQ]);
      wire lastOne = (count <= `ONE_CNT);
      wire [`PTR_W-1:0] firstAddr = dir ? dstPtr : srcPtr;

      assign chEnable[i] = enable;
      assign chReq[i] = req;
      assign chStartAddr[i] = firstPending ? firstAddr : fwdPtr;
      assign chNextAddr[i] = fwdPtr;
      assign doneEvt[i] = myEnd && lastOne;
      assign chRead[i] =
        isChanWord(phaseAddr, CH_ID, `REG_CTRL) ?
          {25'h0000000, sel, 1'b0, req, edgeRise, dir, enable} :
        isChanWord(phaseAddr, CH_ID, `REG_SRC) ? {12'h000, srcPtr} :
        isChanWord(phaseAddr, CH_ID, `REG_DST) ? {12'h000, dstPtr} :
        isChanWord(phaseAddr, CH_ID, `REG_RELOAD) ? {16'h0000, reload} :
        isChanWord(phaseAddr, CH_ID, `REG_FWD) ? {12'h000, fwdPtr} :
        isChanWord(phaseAddr, CH_ID, `REG_COUNT) ? {16'h0000, count} :
        `RST_WORD;

      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          enable <= 1'b0;
          dir <= 1'b0;
          edgeRise <= 1'b0;
          req <= 1'b0;
          firstPending <= 1'b0;
          sel <= `RST_SEL;
          srcPtr <= `RST_PTR;
          dstPtr <= `RST_PTR;
          fwdPtr <= `RST_PTR;
          reload <= `RST_CNT;
          count <= `RST_CNT;
          pinLast <= 1'b1;
        end else begin
          pinLast <= pinLevel[i];
          // a new request wins over any clear in the same cycle
          if (reqEvt) begin
            req <= 1'b1;
          end else if (reqClr) begin
            req <= 1'b0;
          end
          if (ctlWr) begin
            dir <= hwdata[`CTL_DIR];
            edgeRise <= hwdata[`CTL_EDGE];
            sel <= hwdata[`CTL_SEL_HI:`CTL_SEL_LO];
          end
          if (wrStrobe && isChanWord(phaseAddr, CH_ID, `REG_SRC)) begin
            srcPtr <= hwdata[`PTR_W-1:0];
          end
          if (wrStrobe && isChanWord(phaseAddr, CH_ID, `REG_DST)) begin
            dstPtr <= hwdata[`PTR_W-1:0];
          end
          if (wrStrobe && isChanWord(phaseAddr, CH_ID, `REG_RELOAD)) begin
            reload <= hwdata[`CNT_W-1:0];
          end
          // software enable write overrides end-of-count disable
          if (ctlWr && hwdata[`CTL_EN]) begin
            enable <= 1'b1;
            firstPending <= 1'b1;
          end else if (ctlWr) begin
            enable <= 1'b0;
            firstPending <= 1'b0;
          end else if (myEnd && lastOne) begin
            enable <= 1'b0;
          end else if (myStart) begin
            firstPending <= 1'b0;
          end
          if (myStart && firstPending) begin
            fwdPtr <= firstAddr;
            count <= reload;
          end else if (myEnd) begin
            fwdPtr <= fwdPtr + `ONE_PTR;
            count <= count - `ONE_CNT;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // interrupt status (cleared by read) and mask
  // ----------------------------------------------------------------------
  reg [1:0] status;
  reg [1:0] mask;
  wire statusRd = rdStrobe && isGlobalWord(phaseAddr, `REG_STATUS);
  wire maskWr = wrStrobe && isGlobalWord(phaseAddr, `REG_MASK);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= 2'h0;
      mask <= 2'h0;
      irq <= 1'b0;
    end else begin
      // a completion in the read cycle survives the clear
      status <= (statusRd ? 2'h0 : status) | doneEvt;
      if (maskWr) begin
        mask <= hwdata[1:0];
      end
      irq <= |(status & mask);
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= `RST_WORD;
    end else if (rdStrobe) begin
      if (isGlobalWord(phaseAddr, `REG_STATUS)) begin
        hrdata <= {30'h00000000, status};
      end else if (isGlobalWord(phaseAddr, `REG_MASK)) begin
        hrdata <= {30'h00000000, mask};
      end else if (!phaseAddr[`ADR_GLOBAL_BIT]) begin
        hrdata <= chRead[phaseAddr[`ADR_CHAN_BIT]];
      end else begin
        hrdata <= `RST_WORD;
      end
    end
  end

endmodule // dma_request_enable_logic

// ==== dv/dma_chk.sv ====
/* port checker for the two-channel transfer controller.
   assumes hready comes back from hreadyout. */
`timescale 1ns/100ps
module dma_chk (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // bus
  input wire hsel,
  input wire [1:0] htrans,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // transfer side
  input wire dmaOwnsBus,
  input wire dmaChan,
  input wire [19:0] dmaAddr,
  input wire cpuBusReq,
  input wire cpuAccessDone,
  input wire irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire take = hsel && htrans[1] && hready;
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_ready_dip: assert property (take && hreadyout |=> !hreadyout ##1
    hreadyout) else $error("hreadyout dip wrong");
  a_ready_idle: assert property (!take && hreadyout |=> hreadyout)
    else $error("hreadyout dropped while idle");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |->
    $stable(hrdata)) else $error("hrdata moved");
  a_xfer_len: assert property ($rose(dmaOwnsBus) |-> dmaOwnsBus[*2] ##1
    !dmaOwnsBus) else $error("transfer length wrong");
  a_cpu_gap: assert property ($fell(dmaOwnsBus) |=> !dmaOwnsBus)
    else $error("no cpu slot");
  a_cpu_served: assert property ($fell(dmaOwnsBus) && cpuBusReq &&
    !cpuAccessDone |=> !dmaOwnsBus ##1 !dmaOwnsBus)
    else $error("bus retaken before cpu access");
  a_chan_steady: assert property (!$rose(dmaOwnsBus) |-> $stable(dmaChan))
    else $error("channel moved");
  a_addr_quiet: assert property (!dmaOwnsBus && !$past(dmaOwnsBus) |->
    $stable(dmaAddr)) else $error("address moved idle");
  c_chan_one: cover property ($rose(dmaOwnsBus) && dmaChan);
  c_irq: cover property ($rose(irq));
  c_read: cover property (take && hreadyout);
endmodule // dma_chk
bind dma_request_enable_logic dma_chk chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .dmaOwnsBus(dmaOwnsBus), .dmaChan(dmaChan), .dmaAddr(dmaAddr),
  .cpuBusReq(cpuBusReq), .cpuAccessDone(cpuAccessDone),
  .irq(irq));

// ==== dv/cpu_model.sv ====
/* cpu sharing the internal bus: keeps one access pending while the
   controller owns the bus, then makes one access, fast or slow.
   assumes the same clock as the controller. */
`timescale 1ns/100ps
module cpu_model (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // bus sharing
  input wire dmaOwnsBus,
  input wire slowCpu,
  output reg cpuBusReq,
  output reg cpuAccessDone
);
  reg [2:0] cnt;
  integer doneCnt;
  // one access waits out each transfer, then completes
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuBusReq <= 1'b0;
      cpuAccessDone <= 1'b0;
      cnt <= 3'h0;
      doneCnt <= 0;
    end else begin
      cpuAccessDone <= 1'b0;
      if (dmaOwnsBus && !cpuBusReq) begin
        cpuBusReq <= 1'b1;
        cnt <= slowCpu ? 3'h4 : 3'h1;
      end else if (cpuBusReq && !dmaOwnsBus) begin
        cnt <= cnt - 3'h1;
        if (cnt == 3'h1) begin
          cpuBusReq <= 1'b0;
          cpuAccessDone <= 1'b1;
          doneCnt <= doneCnt + 1;
        end
      end
    end
  end
endmodule // cpu_model

// ==== dv/tb_top.sv ====
/* testbench of the transfer controller: ahb-lite master tasks, one task
   a scenario. assumes the cpu model on the bus-sharing side. */
`timescale 1ns/100ps
`include "dma_defines.vh"
module tb_top;
  reg ref_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, slowCpu = 0;
  reg [31:0] haddr = 0, hwdata = 0, rd;
  reg [1:0] htrans = 0, periphIrq = 0, pinLvl = 2'h3;
  wire hreadyout, hresp, dmaOwnsBus, dmaChan, irq, cpuBusReq, cpuAccessDone;
  wire [31:0] hrdata;
  wire [`PTR_W-1:0] dmaAddr;
  integer error_cnt = 0, n_checks = 0, n;
  always #50 ref_clk = ~ref_clk;
  dma_request_enable_logic uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .periphIrq(periphIrq), .external_irq_pin(pinLvl),
    .cpuBusReq(cpuBusReq), .cpuAccessDone(cpuAccessDone),
    .dmaOwnsBus(dmaOwnsBus), .dmaChan(dmaChan), .dmaAddr(dmaAddr),
    .irq(irq));
  cpu_model cpu (.ref_clk(ref_clk), .rst_n(rst_n), .dmaOwnsBus(dmaOwnsBus),
    .slowCpu(slowCpu), .cpuBusReq(cpuBusReq),
    .cpuAccessDone(cpuAccessDone));
  // ----------------------------------------------------------------------
  // report and helpers
  // ----------------------------------------------------------------------
  task end_of_test;
    begin
      $display("errors %0d checks %0d", error_cnt, n_checks);
      if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // wait for dmaOwnsBus (sel 0) or irq (sel 1) to reach v
  task wait_for(input sel, input v);
    integer i;
    begin
      i = 0;
      @(negedge ref_clk);
      while ((sel ? irq : dmaOwnsBus) !== v && i < 60) begin
        @(negedge ref_clk);
        i = i + 1;
      end
      if (i == 60) begin
        chk("wait", v, ~v);
        end_of_test;
      end
    end
  endtask
  // hold the phase until hready is sampled high at a rising edge
  task hold;
    integer i;
    begin
      i = 0;
      @(negedge ref_clk);
      while (hreadyout !== 1'b1 && i < 20) begin
        @(negedge ref_clk);
        i = i + 1;
      end
      if (i == 20) begin
        chk("hready", 1, 0);
        end_of_test;
      end
      @(posedge ref_clk);
      rd = hrdata;
    end
  endtask
  task bus(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      hold;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hold;
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input string nm, input [31:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd);
    end
  endtask
  task pulse(input [1:0] m);
    begin
      @(posedge ref_clk);
      periphIrq <= m;
      @(posedge ref_clk);
      periphIrq <= 2'h0;
    end
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task s_reset;
    begin
      chk("hreadyout", 1, hreadyout);
      chk("irq", 0, irq);
      wr(32'h7C, 32'hFFFFFFFF);
      rdc("unmapped", 32'h7C, 32'h0);
      rdc("ctrl0", 32'h0, 32'h0);
    end
  endtask
  task s_request;
    begin
      pulse(2'h1);
      repeat (2) @(posedge ref_clk);
      rdc("req set", 32'h0, 32'h8);
      wr(32'h0, 32'h8);
      rdc("req w1", 32'h0, 32'h8);
      wr(32'h0, 32'h0);
      rdc("req w0", 32'h0, 32'h0);
    end
  endtask
  task s_enable;
    begin
      wr(32'h04, 32'h123);
      wr(32'h08, 32'h456);
      wr(32'h0C, 32'h2);
      wr(32'h00, 32'h1);
      rdc("enable", 32'h0, 32'h1);
      pulse(2'h1);
      wait_for(0, 1);
      chk("src fwd", 32'h123, dmaAddr);
      wait_for(0, 0);
      rdc("req clr", 32'h0, 32'h1);
      rdc("count", 32'h14, 32'h1);
      rdc("fwd ptr", 32'h10, 32'h124);
      rdc("reload", 32'h0C, 32'h2);
      wr(32'h00, 32'h3);
      pulse(2'h1);
      wait_for(0, 1);
      chk("dst fwd", 32'h456, dmaAddr);
      wait_for(0, 0);
      rdc("recount", 32'h14, 32'h1);
      wr(32'h44, 32'h1);
      rdc("mask", 32'h44, 32'h1);
      pulse(2'h1);
      wait_for(1, 1);
      rdc("off", 32'h0, 32'h2);
      rdc("status", 32'h40, 32'h1);
      repeat (3) @(posedge ref_clk);
      chk("irq clr", 0, irq);
    end
  endtask
  task s_pins;
    begin
      slowCpu <= 1'b1;
      wr(32'h04, 32'h10);
      wr(32'h24, 32'h20);
      wr(32'h0C, 32'h5);
      wr(32'h2C, 32'h5);
      wr(32'h00, 32'h41);
      wr(32'h20, 32'h41);
      wr(32'h00, 32'h41);
      wr(32'h20, 32'h41);
      @(posedge ref_clk);
      pinLvl <= 2'h0;
      wait_for(0, 1);
      chk("first chan", 0, dmaChan);
      chk("pin addr0", 32'h10, dmaAddr);
      n = cpu.doneCnt;
      wait_for(0, 0);
      wait_for(0, 1);
      chk("second chan", 1, dmaChan);
      chk("cpu access", n + 1, cpu.doneCnt);
      chk("pin addr1", 32'h20, dmaAddr);
      wait_for(0, 0);
      wr(32'h00, 32'h45);
      @(posedge ref_clk);
      pinLvl <= 2'h1;
      wait_for(0, 1);
      chk("rise chan", 0, dmaChan);
      wait_for(0, 0);
    end
  endtask
  task s_soft;
    begin
      slowCpu <= 1'b0;
      wr(32'h20, 32'h31);
      wait_for(0, 1);
      chk("soft chan", 1, dmaChan);
      wait_for(0, 0);
      rdc("soft bit", 32'h20, 32'h21);
    end
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    s_reset;
    s_request;
    s_enable;
    s_pins;
    s_soft;
    end_of_test;
  end
endmodule // tb_top
